/* hdl/bpms_pkg.sv */
// Package with constants, states and carrier structs for the ballast power-mode sequencer.
package bpms_pkg;

    // Clock rate in kHz and the two documented intervals in microseconds.
    localparam int CLK_KHZ = 40000;
    localparam int ENTRY_DELAY_US = 10;
    localparam int IDLE_TIMEOUT_US = 100;
    // Least time rounds up, the longest time rounds down.
    localparam int ENTRY_CYCLES = (ENTRY_DELAY_US * CLK_KHZ + 999) / 1000;
    localparam int IDLE_CYCLES = (IDLE_TIMEOUT_US * CLK_KHZ) / 1000;
    localparam int CNT_W = 13;
    localparam logic [CNT_W-1:0] CNT_RESET = 13'h0000;

    // AXI4-Lite register byte offsets.
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    // Control register field positions and reset value.
    localparam int CTRL_FAULT_CLR_BIT = 0;
    localparam int CTRL_FORCE_SAVE_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // Status register field positions.
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_FAULT_BIT = 2;
    localparam int STAT_DRV_EN_BIT = 3;
    localparam int STAT_SWITCH_BIT = 4;
    localparam int STAT_REF_HI_BIT = 5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Power modes of the sequencer.
    typedef enum logic [1:0] {
        MODE_STARTUP,
        MODE_SAVE,
        MODE_OPERATING,
        MODE_SHUTDOWN
    } bpms_mode_t;

    // Comparator results, all taken as synchronous levels.
    typedef struct packed {
        logic supply_turn_on_threshold;
        logic supply_save_low_threshold;
        logic supply_turn_off_threshold;
        logic ref_off_threshold;
        logic regulator_start_threshold;
        logic regulator_on_threshold;
        logic regulator_off_threshold;
        logic ref_good;
        logic ref_low;
        logic current_sense;
    } bpms_cmp_t;

    // Gate logic inputs from the microcontroller.
    typedef struct packed {
        logic high_side_gate_in;
        logic low_side_gate_in;
        logic pfc_gate_in;
        logic heater_gate_in;
    } bpms_gate_in_t;

    // Gate outputs and bootstrap switch.
    typedef struct packed {
        logic high_side_gate_out;
        logic low_side_gate_out;
        logic pfc_gate_out;
        logic heater_gate_out;
        logic bootstrap_switch;
    } bpms_gate_out_t;

    // Analog control levels.
    typedef struct packed {
        logic hv_startup_generator;
        logic ref_enable;
        logic ref_high_current;
        logic ref_sink_enable;
        logic two_point_regulator;
        logic supply_switch;
        logic overcurrent_protect;
        logic boot_reverse_block;
    } bpms_ctl_t;

    // Whole state of the sequencer.
    typedef struct packed {
        bpms_mode_t mode;
        logic [CNT_W-1:0] save_cnt;
        logic [CNT_W-1:0] idle_cnt;
        logic hs_d;
        logic ls_d;
        logic fault;
        logic [1:0] ctrl;
        bpms_ctl_t ctl;
        bpms_gate_out_t gate;
        logic flag_out;
        logic awv;
        logic wv;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } bpms_state_t;

endpackage

/* hdl/bpms_top.sv */
// Ballast power-mode sequencer with gate drive gating, fault latch and register slave.
//
// Function
// - Four modes: start-up, save, operating, shutdown.
// - Over-current protection independent, enabled only operating.
// - Start-up: generator on, reference sunk, rest off.
// - Turn-on threshold reached: generator off, go save.
// - Save, no activity: generator cycles between thresholds.
// - Save: reference low-current, regulator and drivers off.
// - Save below reference-off threshold returns to start-up.
// - Operating on high-side fall after 10us, reference good.
// - Operating: generator off, reference high, everything enabled.
// - No low-side activity over 100us returns save.
// - Operating to shutdown on supply or reference undervoltage.
// - Shutdown: generator on, reference low, rest off.
// - Shutdown to save on turn-on, else start-up below reference-off threshold.
// - Supply above start threshold closes switch immediately.
// - Between on and start: close at low-side fall.
// - Below off threshold: open at low-side fall.
// - Reference off below its threshold, sink re-enabled.
// - Bootstrap follows low-side gate; reverse flow always blocked.
// - Gate outputs follow inputs when enabled, else low.
// - Current trip latches fault, half-bridge low, flag high.
// - Both half-bridge inputs high force both outputs low.
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps

module bpms_top (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Comparator results and gate inputs.
    input wire bpms_pkg::bpms_cmp_t cmp,
    input wire bpms_pkg::bpms_gate_in_t gate_in,
    // Gate outputs, analog controls and fault flag.
    output bpms_pkg::bpms_gate_out_t gate_out,
    output bpms_pkg::bpms_ctl_t ctl_out,
    output logic overcurrent_flag_out,
    // AXI4-Lite write address and data.
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    bpms_pkg::bpms_state_t st_r;
    bpms_pkg::bpms_state_t st_nxt;

    // Latched write address and data while waiting for their partner.
    logic [3:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;

    // Raw per-gate enables before interlock and fault forcing.
    logic [3:0] gate_raw;
    logic [3:0] gate_in_v;

    assign gate_in_v = {gate_in.high_side_gate_in, gate_in.low_side_gate_in,
                        gate_in.pfc_gate_in, gate_in.heater_gate_in};

    // Each gate follows its input only while drivers are enabled.
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_gate
            assign gate_raw[g] = gate_in_v[g] & (st_nxt.mode == bpms_pkg::MODE_OPERATING);
        end
    endgenerate

    // Registers all state on every rising clock edge.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.mode <= bpms_pkg::MODE_STARTUP;
            st_r.save_cnt <= bpms_pkg::CNT_RESET;
            st_r.idle_cnt <= bpms_pkg::CNT_RESET;
            st_r.ctrl <= bpms_pkg::CTRL_RESET;
            st_r.ctl.hv_startup_generator <= 1'b1;
            st_r.ctl.ref_sink_enable <= 1'b1;
            st_r.ctl.boot_reverse_block <= 1'b1;
            awaddr_r <= 4'h0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else begin
            st_r <= st_nxt;
            if (s_axi_awvalid && !st_r.awv) begin
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !st_r.wv) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
        end
    end

    // Next-state logic for modes, timers, regulator, fault and bus.
    always_comb begin
        logic hs_fall;
        logic ls_fall;
        logic ls_act;
        logic wr_fire;
        logic [3:0] wa;
        logic [31:0] wd;
        logic [3:0] ws;
        st_nxt = st_r;
        wr_fire = 1'b0;
        wa = st_r.awv ? awaddr_r : s_axi_awaddr;
        wd = st_r.wv ? wdata_r : s_axi_wdata;
        ws = st_r.wv ? wstrb_r : s_axi_wstrb;
        hs_fall = st_r.hs_d & ~gate_in.high_side_gate_in;
        ls_fall = st_r.ls_d & ~gate_in.low_side_gate_in;
        ls_act = st_r.ls_d ^ gate_in.low_side_gate_in;
        st_nxt.hs_d = gate_in.high_side_gate_in;
        st_nxt.ls_d = gate_in.low_side_gate_in;
        st_nxt.ctrl[bpms_pkg::CTRL_FAULT_CLR_BIT] = 1'b0;
        st_nxt.ctrl[bpms_pkg::CTRL_FORCE_SAVE_BIT] = 1'b0;

        // Interval counters driven by the internal clock.
        if (st_r.mode == bpms_pkg::MODE_SAVE) begin
            if (st_r.save_cnt != bpms_pkg::ENTRY_CYCLES[bpms_pkg::CNT_W-1:0]) begin
                st_nxt.save_cnt = st_r.save_cnt + 13'h0001;
            end
        end else begin
            st_nxt.save_cnt = bpms_pkg::CNT_RESET;
        end
        if (st_r.mode != bpms_pkg::MODE_OPERATING || ls_act) begin
            st_nxt.idle_cnt = bpms_pkg::CNT_RESET;
        end else if (st_r.idle_cnt != bpms_pkg::IDLE_CYCLES[bpms_pkg::CNT_W-1:0]) begin
            st_nxt.idle_cnt = st_r.idle_cnt + 13'h0001;
        end

        // Mode transitions.
        case (st_r.mode)
            bpms_pkg::MODE_STARTUP: begin
                if (cmp.supply_turn_on_threshold) begin
                    st_nxt.mode = bpms_pkg::MODE_SAVE;
                end
            end
            bpms_pkg::MODE_SAVE: begin
                if (!cmp.ref_off_threshold) begin
                    st_nxt.mode = bpms_pkg::MODE_STARTUP;
                end else if (hs_fall && cmp.ref_good && !st_r.ctrl[1]
                             && st_r.save_cnt == bpms_pkg::ENTRY_CYCLES[bpms_pkg::CNT_W-1:0]) begin
                    st_nxt.mode = bpms_pkg::MODE_OPERATING;
                end
            end
            bpms_pkg::MODE_OPERATING: begin
                if (!cmp.supply_turn_off_threshold || cmp.ref_low) begin
                    st_nxt.mode = bpms_pkg::MODE_SHUTDOWN;
                end else if (st_r.ctrl[bpms_pkg::CTRL_FORCE_SAVE_BIT] || (!ls_act
                             && st_r.idle_cnt == bpms_pkg::IDLE_CYCLES[bpms_pkg::CNT_W-1:0])) begin
                    st_nxt.mode = bpms_pkg::MODE_SAVE;
                end
            end
            bpms_pkg::MODE_SHUTDOWN: begin
                if (cmp.supply_turn_on_threshold) begin
                    st_nxt.mode = bpms_pkg::MODE_SAVE;
                end else if (!cmp.ref_off_threshold) begin
                    st_nxt.mode = bpms_pkg::MODE_STARTUP;
                end
            end
            default: begin
                st_nxt.mode = bpms_pkg::MODE_STARTUP;
            end
        endcase

        // Analog controls per next mode.
        st_nxt.ctl.boot_reverse_block = 1'b1;
        st_nxt.ctl.two_point_regulator = (st_nxt.mode == bpms_pkg::MODE_OPERATING);
        st_nxt.ctl.overcurrent_protect = (st_nxt.mode == bpms_pkg::MODE_OPERATING);
        st_nxt.ctl.ref_high_current = (st_nxt.mode == bpms_pkg::MODE_OPERATING);
        st_nxt.ctl.ref_enable = (st_nxt.mode != bpms_pkg::MODE_STARTUP)
                                && cmp.ref_off_threshold;
        st_nxt.ctl.ref_sink_enable = !st_nxt.ctl.ref_enable;
        case (st_nxt.mode)
            bpms_pkg::MODE_STARTUP: st_nxt.ctl.hv_startup_generator = 1'b1;
            bpms_pkg::MODE_SHUTDOWN: st_nxt.ctl.hv_startup_generator = 1'b1;
            bpms_pkg::MODE_OPERATING: st_nxt.ctl.hv_startup_generator = 1'b0;
            bpms_pkg::MODE_SAVE: begin
                if (st_r.mode != bpms_pkg::MODE_SAVE) begin
                    st_nxt.ctl.hv_startup_generator = 1'b0;
                end else if (cmp.supply_turn_on_threshold) begin
                    st_nxt.ctl.hv_startup_generator = 1'b0;
                end else if (!cmp.supply_save_low_threshold) begin
                    st_nxt.ctl.hv_startup_generator = 1'b1;
                end
            end
            default: st_nxt.ctl.hv_startup_generator = 1'b1;
        endcase

        // Two-point regulator controls the supply switch.
        if (st_nxt.mode != bpms_pkg::MODE_OPERATING) begin
            st_nxt.ctl.supply_switch = 1'b0;
        end else if (cmp.regulator_start_threshold) begin
            st_nxt.ctl.supply_switch = 1'b1;
        end else if (ls_fall && cmp.regulator_on_threshold) begin
            st_nxt.ctl.supply_switch = 1'b1;
        end else if (ls_fall && !cmp.regulator_off_threshold) begin
            st_nxt.ctl.supply_switch = 1'b0;
        end

        // Over-current fault latch; a new trip wins over release.
        if (st_nxt.ctl.overcurrent_protect && cmp.current_sense) begin
            st_nxt.fault = 1'b1;
        end else if (!gate_in.high_side_gate_in && !gate_in.low_side_gate_in
                     && !cmp.current_sense) begin
            st_nxt.fault = 1'b0;
        end
        st_nxt.flag_out = st_nxt.fault;

        // Gate outputs with interlock and fault forcing.
        st_nxt.gate.pfc_gate_out = gate_raw[1];
        st_nxt.gate.heater_gate_out = gate_raw[0];
        st_nxt.gate.high_side_gate_out = gate_raw[3] & ~st_nxt.fault
                                         & ~(gate_in_v[3] & gate_in_v[2]);
        st_nxt.gate.low_side_gate_out = gate_raw[2] & ~st_nxt.fault
                                        & ~(gate_in_v[3] & gate_in_v[2]);
        st_nxt.gate.bootstrap_switch = st_nxt.gate.low_side_gate_out;

        // AXI4-Lite write channel: accept address and data in any order.
        if (s_axi_awvalid && !st_r.awv) begin
            st_nxt.awv = 1'b1;
        end
        if (s_axi_wvalid && !st_r.wv) begin
            st_nxt.wv = 1'b1;
        end
        wr_fire = st_nxt.awv && st_nxt.wv && !st_r.bvalid;
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (wr_fire) begin
            st_nxt.awv = 1'b0;
            st_nxt.wv = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = bpms_pkg::RESP_OKAY;
            if (wa == bpms_pkg::CTRL_OFS) begin
                if (ws[0]) begin
                    st_nxt.ctrl = wd[1:0];
                end
            end else if (wa != bpms_pkg::STATUS_OFS) begin
                st_nxt.bresp = bpms_pkg::RESP_SLVERR;
            end
        end

        // AXI4-Lite read channel.
        st_nxt.arready = !st_r.rvalid && !st_r.arready;
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.arready = 1'b0;
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = bpms_pkg::RESP_OKAY;
            st_nxt.rdata = 32'h0000_0000;
            if (s_axi_araddr == bpms_pkg::STATUS_OFS) begin
                st_nxt.rdata[bpms_pkg::STAT_MODE_LSB +: 2] = st_r.mode;
                st_nxt.rdata[bpms_pkg::STAT_FAULT_BIT] = st_r.fault;
                st_nxt.rdata[bpms_pkg::STAT_DRV_EN_BIT] = (st_r.mode == bpms_pkg::MODE_OPERATING);
                st_nxt.rdata[bpms_pkg::STAT_SWITCH_BIT] = st_r.ctl.supply_switch;
                st_nxt.rdata[bpms_pkg::STAT_REF_HI_BIT] = st_r.ctl.ref_high_current;
            end else if (s_axi_araddr != bpms_pkg::CTRL_OFS) begin
                st_nxt.rresp = bpms_pkg::RESP_SLVERR;
            end
        end
    end

    // Outputs straight from the state register.
    assign gate_out = st_r.gate;
    assign ctl_out = st_r.ctl;
    assign overcurrent_flag_out = st_r.flag_out;
    assign s_axi_awready = !st_r.awv;
    assign s_axi_wready = !st_r.wv;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;

endmodule

/* tb/bpms_assertions.sv */
// Port-level assertions for the ballast power-mode sequencer.
`timescale 1ns/1ps
module bpms_checker (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Comparators, gate pins and controls.
    input wire bpms_pkg::bpms_cmp_t cmp,
    input wire bpms_pkg::bpms_gate_in_t gate_in,
    input wire bpms_pkg::bpms_gate_out_t gate_out,
    input wire bpms_pkg::bpms_ctl_t ctl_out,
    input wire logic overcurrent_flag_out,
    // Register bus handshakes.
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    // Short names for the watched pins.
    wire hso = gate_out.high_side_gate_out;
    wire lso = gate_out.low_side_gate_out;
    wire prot = ctl_out.overcurrent_protect;
    wire flg = overcurrent_flag_out;
    wire hbi = gate_in.high_side_gate_in || gate_in.low_side_gate_in;

    default clocking dcb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Mode controls, gate gating, fault latch and bus answers.
    AST_BOOT_BLOCK: assert property (ctl_out.boot_reverse_block)
        else $error("reverse block released");
    AST_BOOT_SYNC: assert property (gate_out.bootstrap_switch == lso)
        else $error("bootstrap switch apart from low side");
    AST_OPER_CTL: assert property (prot |-> !ctl_out.hv_startup_generator &&
        ctl_out.ref_high_current && ctl_out.two_point_regulator && ctl_out.ref_enable)
        else $error("operating controls wrong");
    AST_IDLE_CTL: assert property (!prot |-> !ctl_out.two_point_regulator &&
        !ctl_out.supply_switch && !ctl_out.ref_high_current)
        else $error("regulator on outside operating");
    AST_START_EXIT: assert property (ctl_out.ref_sink_enable &&
        cmp.supply_turn_on_threshold && cmp.ref_off_threshold
        |-> ##[1:2] !ctl_out.hv_startup_generator)
        else $error("generator still on after turn-on");
    AST_GATE_OFF: assert property (!prot && $past(!prot) |-> gate_out[4:1] == 4'h0)
        else $error("gate driven while disabled");
    AST_FOLLOW: assert property (prot && $past(prot) |->
        gate_out.pfc_gate_out == $past(gate_in.pfc_gate_in) &&
        gate_out.heater_gate_out == $past(gate_in.heater_gate_in))
        else $error("gate output does not follow input");
    AST_HB_FOLLOW: assert property (prot && !flg &&
        !$past(gate_in.high_side_gate_in && gate_in.low_side_gate_in) |->
        hso == $past(gate_in.high_side_gate_in) && lso == $past(gate_in.low_side_gate_in))
        else $error("half bridge output does not follow input");
    AST_INTERLOCK: assert property (gate_in.high_side_gate_in &&
        gate_in.low_side_gate_in |=> !hso && !lso)
        else $error("half bridge driven during overlap");
    AST_TRIP: assert property (cmp.current_sense ##1 prot |-> flg)
        else $error("fault not latched");
    AST_FAULT_GATES: assert property (flg && $past(flg) |-> !hso && !lso)
        else $error("half bridge driven in fault");
    AST_FAULT_HOLD: assert property (flg && hbi && $past(hbi) |=> flg)
        else $error("fault cleared with input high");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule

/* tb/bpms_mcu_model.sv */
// Behavioural microcontroller that drives the four gate logic inputs.
`timescale 1ns/1ps
module bpms_mcu_model #(
    parameter int HALF = 20
) (
    // Clock and command: 0 idle, 1 switching, 2 both sides high.
    input wire logic aclk,
    input wire logic [1:0] cmd,
    // Gate logic levels.
    output bpms_pkg::bpms_gate_in_t gate_in
);
    int cnt = 0;
    initial gate_in = '0;
    // Half bridge with two cycles of dead time at each change, random side drivers.
    always @(posedge aclk) begin
        cnt <= (cnt + 1) % (2 * HALF);
        gate_in.high_side_gate_in <= cmd == 2'h2 || (cmd == 2'h1 && cnt >= 2 && cnt < HALF);
        gate_in.low_side_gate_in <= cmd == 2'h2 || (cmd == 2'h1 && cnt >= HALF + 2);
        gate_in.pfc_gate_in <= cmd != 2'h0 && $urandom_range(1) != 0;
        gate_in.heater_gate_in <= cmd != 2'h0 && $urandom_range(1) != 0;
    end
endmodule

/* tb/bpms_tb.sv */
// Self-checking bench for the ballast power-mode sequencer.
`timescale 1ns/1ps
module bpms_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    bpms_pkg::bpms_cmp_t cmp = '0;
    bpms_pkg::bpms_gate_in_t gate_in;
    bpms_pkg::bpms_gate_out_t gate_out;
    bpms_pkg::bpms_ctl_t ctl_out;
    logic overcurrent_flag_out, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic [3:0] s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [1:0] cmd = 2'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, rd;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;

    bpms_top bpms_top_i (
        .aclk(aclk), .aresetn(aresetn), .cmp(cmp), .gate_in(gate_in), .gate_out(gate_out),
        .ctl_out(ctl_out), .overcurrent_flag_out(overcurrent_flag_out),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );
    bpms_mcu_model bpms_mcu_model_i (.aclk(aclk), .cmd(cmd), .gate_in(gate_in));

    // Clock and hang guard.
    always #12.5 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("CHECK FAILED at %0t: timeout", $time);
            finish_test();
        end
    end

    task automatic finish_test();
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Expected controls for a mode, supply switch left out.
    function automatic logic [7:0] ctl_exp(input logic [1:0] m, input logic hv);
        case (m)
            2'h0: return 8'h91;
            2'h1: return {hv, 7'h41};
            2'h2: return 8'h6b;
            default: return 8'hc1;
        endcase
    endfunction

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk(s_axi_bvalid, 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [3:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk(s_axi_rvalid, 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    // Settles, then compares controls and the reported mode.
    task automatic st(input logic [1:0] m, input logic hv);
        wt(2);
        chk(ctl_out & 8'hfb, ctl_exp(m, hv));
        axi_rd(bpms_pkg::STATUS_OFS);
        chk(rd[1:0], m);
        chk({rd[5], rd[3:2]}, {m == 2'h2, m == 2'h2, 1'b0});
    endtask

    task automatic sup(input logic [3:0] v);
        {cmp.supply_turn_on_threshold, cmp.supply_save_low_threshold} <= v[3:2];
        {cmp.supply_turn_off_threshold, cmp.ref_off_threshold} <= v[1:0];
    endtask

    task automatic go_oper();
        int n;
        n = 0;
        cmd <= 2'h1;
        while (ctl_out.overcurrent_protect !== 1'b1 && n < 800) begin
            @(posedge aclk);
            n++;
        end
        chk(ctl_out.overcurrent_protect, 1'b1);
    endtask

    // Main sequence.
    initial begin
        void'($urandom(11));
        wt(20);
        aresetn <= 1'b1;
        wt(1);
        chk({gate_out, overcurrent_flag_out}, 6'h00);
        st(bpms_pkg::MODE_STARTUP, 1'b1);
        axi_rd(4'h8);
        chk(rs, bpms_pkg::RESP_SLVERR);
        axi_wr(bpms_pkg::CTRL_OFS, 32'h1);
        chk(rs, bpms_pkg::RESP_OKAY);
        axi_rd(bpms_pkg::CTRL_OFS);
        chk(rd, 32'h0);
        sup(4'hf);
        cmp.ref_good <= 1'b1;
        {cmp.regulator_on_threshold, cmp.regulator_off_threshold} <= 2'h3;
        st(bpms_pkg::MODE_SAVE, 1'b0);
        sup(4'h3);
        st(bpms_pkg::MODE_SAVE, 1'b1);
        sup(4'hf);
        st(bpms_pkg::MODE_SAVE, 1'b0);
        cmd <= 2'h1;
        wt(250);
        st(bpms_pkg::MODE_SAVE, 1'b0);
        cmp.ref_good <= 1'b0;
        wt(200);
        st(bpms_pkg::MODE_SAVE, 1'b0);
        cmp.ref_good <= 1'b1;
        go_oper();
        st(bpms_pkg::MODE_OPERATING, 1'b0);
        // Supply below off opens the switch at each low-side fall; only start can close it.
        {cmp.regulator_on_threshold, cmp.regulator_off_threshold} <= 2'h0;
        repeat (20) begin
            cmp.regulator_start_threshold <= 1'($urandom_range(1));
            wt(2);
            if (cmp.regulator_start_threshold) chk(ctl_out.supply_switch, 1'b1);
        end
        cmp.regulator_start_threshold <= 1'b0;
        @(negedge gate_in.low_side_gate_in);
        wt(3);
        chk(ctl_out.supply_switch, 1'b0);
        {cmp.regulator_on_threshold, cmp.regulator_off_threshold} <= 2'h3;
        @(negedge gate_in.low_side_gate_in);
        wt(3);
        chk(ctl_out.supply_switch, 1'b1);
        cmp.current_sense <= 1'b1;
        wt(1);
        cmp.current_sense <= 1'b0;
        wt(1);
        chk(overcurrent_flag_out, 1'b1);
        cmd <= 2'h0;
        wt(4);
        chk(overcurrent_flag_out, 1'b0);
        cmd <= 2'h2;
        wt(3);
        chk({gate_out.high_side_gate_out, gate_out.low_side_gate_out}, 2'h0);
        cmd <= 2'h0;
        wt(3900);
        chk(ctl_out.overcurrent_protect, 1'b1);
        wt(150);
        st(bpms_pkg::MODE_SAVE, 1'b0);
        go_oper();
        // Force-save bit of the control register drops operating back to save.
        axi_wr(bpms_pkg::CTRL_OFS, 32'h2);
        st(bpms_pkg::MODE_SAVE, 1'b0);
        go_oper();
        sup(4'h1);
        st(bpms_pkg::MODE_SHUTDOWN, 1'b1);
        sup(4'hf);
        st(bpms_pkg::MODE_SAVE, 1'b0);
        sup(4'h0);
        st(bpms_pkg::MODE_STARTUP, 1'b1);
        sup(4'hf);
        wt(2);
        go_oper();
        sup(4'h7);
        cmp.ref_low <= 1'b1;
        st(bpms_pkg::MODE_SHUTDOWN, 1'b1);
        sup(4'h0);
        st(bpms_pkg::MODE_STARTUP, 1'b1);
        finish_test();
    end
endmodule

bind bpms_top bpms_checker bpms_checker_i (
    .aclk(aclk), .aresetn(aresetn), .cmp(cmp), .gate_in(gate_in), .gate_out(gate_out),
    .ctl_out(ctl_out), .overcurrent_flag_out(overcurrent_flag_out),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid)
);
